// ==== core/rps_params.svh ====
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RPS_OFF_EXT_INT2 8'h00
`define RPS_OFF_SPI1 8'h04
`define RPS_OFF_PIN2021 8'h08
`define RPS_OFF_LOCK 8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RPS_SEL_W 5
`define RPS_LO_LSB 0
`define RPS_HI_LSB 8
`define RPS_LOCK_BIT 6

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define RPS_TIE_LOW_CODE 5'h1F
`define RPS_MAX_PIN_CODE 5'h19
`define RPS_IN_RESET 5'h1F
`define RPS_OUT_RESET 5'h00
`define RPS_NUM_PINS 26
`define RPS_NUM_FUNCS 32

`endif

// ==== core/rps_pkg.sv ====
package rps_pkg;
	typedef logic [4:0] rps_sel_t;
	typedef enum logic [1:0] {
		RPS_IDLE,
		RPS_ANSWER
	} rps_bus_state_t;
endpackage

// ==== core/rps_in_mux.sv ====
`timescale 1ns/10ps
`include "rps_params.svh"

// Picks one remappable pin by code, or low for reserved codes
module rps_in_mux #(
	parameter int NUM_PINS = `RPS_NUM_PINS
) (
	input wire logic [NUM_PINS-1:0] pins_i,
	input wire rps_pkg::rps_sel_t sel_i,
	output logic value_o
);
	// Code 11111 and unused codes tie the input low
	always_comb begin
		if (sel_i != `RPS_TIE_LOW_CODE && int'(sel_i) < NUM_PINS) begin
			value_o = pins_i[sel_i];
		end else begin
			value_o = 1'b0;
		end
	end
endmodule

// ==== core/rps_out_mux.sv ====
`timescale 1ns/10ps
`include "rps_params.svh"

// Picks one peripheral output by function number
module rps_out_mux #(
	parameter int NUM_FUNCS = `RPS_NUM_FUNCS
) (
	input wire logic [NUM_FUNCS-1:0] funcs_i,
	input wire rps_pkg::rps_sel_t sel_i,
	output logic value_o
);
	// Function numbers beyond the table drive low
	always_comb begin
		if (int'(sel_i) < NUM_FUNCS) begin
			value_o = funcs_i[sel_i];
		end else begin
			value_o = 1'b0;
		end
	end
endmodule

// ==== core/rps_top.sv ====
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`include "rps_params.svh"

// Operation
// - Interrupt two input from its selector
// - Codes 0 to 25 pick that pin
// - Code 11111 ties input low
// - SPI1 clock from bits 12 to 8
// - SPI1 data from bits 4 to 0
// - Pin 21 function from bits 12 to 8
// - Pin 20 function from bits 4 to 0
// - Interrupt select upper bits read zero
// - Pin 20/21 register only in 44-pin
// - Selector writes blocked while lock set
module rps_top #(
	parameter int NUM_PINS = `RPS_NUM_PINS,
	parameter int NUM_FUNCS = `RPS_NUM_FUNCS,
	parameter bit HAS_44_PIN = 1'b1
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	input wire logic [NUM_PINS-1:0] remappable_pin_i,
	input wire logic [NUM_FUNCS-1:0] periph_func_i,
	output logic external_interrupt_two_o,
	output logic spi1_clock_in_o,
	output logic spi1_data_in_o,
	output logic pin20_out_o,
	output logic pin21_out_o
);
	// ----------------------------------------
	// Selector state
	// ----------------------------------------
	rps_pkg::rps_sel_t ext_int2_pin_sel;
	rps_pkg::rps_sel_t spi1_clock_pin_sel;
	rps_pkg::rps_sel_t spi1_data_in_pin_sel;
	rps_pkg::rps_sel_t pin20_function_sel;
	rps_pkg::rps_sel_t pin21_function_sel;
	logic [15:0] oscillator_control_reg;
	logic pin_config_lock;
	rps_pkg::rps_bus_state_t bus_state;
	logic [7:0] byte_addr;
	logic wr_hit;
	logic lo_en;
	logic hi_en;
	logic sel_wr_ok;
	logic addr_ok;
	logic req_taken;
	logic [15:0] next_rdata;
	logic int2_raw;
	logic sck_raw;
	logic sdi_raw;
	logic p20_raw;
	logic p21_raw;

	// Word address to byte address
	assign byte_addr = {2'b00, avs_address_i, 2'b00};
	assign pin_config_lock = oscillator_control_reg[`RPS_LOCK_BIT];
	assign wr_hit = avs_write_i && (bus_state == rps_pkg::RPS_IDLE);
	// Registers are 16 bits wide, so only lanes 0 and 1 count
	assign lo_en = avs_byteenable_i[0];
	assign hi_en = avs_byteenable_i[1];
	assign sel_wr_ok = wr_hit && !pin_config_lock;

	// Request taken only from idle, never in the answer cycle,
	// so a request still held at its answer is not taken twice
	assign req_taken = bus_state == rps_pkg::RPS_IDLE &&
		(avs_read_i || avs_write_i);

	// Checks whether an address is mapped
	function automatic logic mapped(input logic [7:0] a, input bit big);
		begin
			mapped = (a == `RPS_OFF_EXT_INT2) || (a == `RPS_OFF_SPI1) ||
				(a == `RPS_OFF_LOCK) || (big && (a == `RPS_OFF_PIN2021));
		end
	endfunction

	assign addr_ok = mapped(byte_addr, HAS_44_PIN);

	// Pulls one selector field out of the write data
	function automatic rps_pkg::rps_sel_t sel_field(input logic [31:0] d,
		input int lsb);
		begin
			sel_field = d[lsb +: `RPS_SEL_W];
		end
	endfunction

	// Packs two selectors into a register word, unused bits zero
	function automatic logic [15:0] pack_pair(input rps_pkg::rps_sel_t hi,
		input rps_pkg::rps_sel_t lo);
		begin
			pack_pair = 16'h0000;
			pack_pair[`RPS_HI_LSB +: `RPS_SEL_W] = hi;
			pack_pair[`RPS_LO_LSB +: `RPS_SEL_W] = lo;
		end
	endfunction

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	// One wait cycle, answer on the second edge
	// A request held past its answer is taken again one edge later
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			bus_state <= rps_pkg::RPS_IDLE;
		end else if (req_taken) begin
			bus_state <= rps_pkg::RPS_ANSWER;
		end else begin
			bus_state <= rps_pkg::RPS_IDLE;
		end
	end

	// Waitrequest low only in the answer cycle
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= !req_taken;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// interrupt two selector, only bits 4 to 0 stored
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			ext_int2_pin_sel <= `RPS_IN_RESET;
		end else if (sel_wr_ok && lo_en &&
			byte_addr == `RPS_OFF_EXT_INT2) begin
			ext_int2_pin_sel <= sel_field(avs_writedata_i, `RPS_LO_LSB);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			spi1_clock_pin_sel <= `RPS_IN_RESET;
			spi1_data_in_pin_sel <= `RPS_IN_RESET;
		end else if (sel_wr_ok && byte_addr == `RPS_OFF_SPI1) begin
			if (hi_en) begin
				spi1_clock_pin_sel <=
					sel_field(avs_writedata_i, `RPS_HI_LSB);
			end
			if (lo_en) begin
				spi1_data_in_pin_sel <=
					sel_field(avs_writedata_i, `RPS_LO_LSB);
			end
		end
	end

	// output register exists only on 44-pin build
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			pin20_function_sel <= `RPS_OUT_RESET;
			pin21_function_sel <= `RPS_OUT_RESET;
		end else if (HAS_44_PIN && sel_wr_ok &&
			byte_addr == `RPS_OFF_PIN2021) begin
			if (hi_en) begin
				pin21_function_sel <=
					sel_field(avs_writedata_i, `RPS_HI_LSB);
			end
			if (lo_en) begin
				pin20_function_sel <=
					sel_field(avs_writedata_i, `RPS_LO_LSB);
			end
		end
	end

	// Oscillator control word, always writable
	// Lock bit is never locked itself, so software can always reopen
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			oscillator_control_reg <= 16'h0000;
		end else if (wr_hit && byte_addr == `RPS_OFF_LOCK) begin
			if (lo_en) begin
				oscillator_control_reg[7:0] <= avs_writedata_i[7:0];
			end
			if (hi_en) begin
				oscillator_control_reg[15:8] <= avs_writedata_i[15:8];
			end
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// read mux with zero fill
	always_comb begin
		next_rdata = 16'h0000;
		unique case (byte_addr)
			`RPS_OFF_EXT_INT2: begin
				next_rdata[`RPS_LO_LSB +: `RPS_SEL_W] = ext_int2_pin_sel;
			end
			`RPS_OFF_SPI1: begin
				next_rdata = pack_pair(spi1_clock_pin_sel,
					spi1_data_in_pin_sel);
			end
			`RPS_OFF_PIN2021: begin
				// Small build reads this word as zero
				if (HAS_44_PIN) begin
					next_rdata = pack_pair(pin21_function_sel,
						pin20_function_sel);
				end
			end
			`RPS_OFF_LOCK: begin
				next_rdata = oscillator_control_reg;
			end
			// Unmapped addresses read zero
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	// Read data and response captured with the answer
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			avs_readdata_o <= 32'h0000_0000;
			avs_response_o <= 2'b00;
		end else if (req_taken) begin
			avs_readdata_o <= avs_read_i ? {16'h0000, next_rdata} :
				32'h0000_0000;
			// Unmapped addresses answer with the decode error code
			avs_response_o <= addr_ok ? 2'b00 : 2'b11;
		end
	end

	// ----------------------------------------
	// Pin routing
	// ----------------------------------------
	// interrupt two input mux
	rps_in_mux #(.NUM_PINS(NUM_PINS)) u_int2 (
		.pins_i(remappable_pin_i),
		.sel_i(ext_int2_pin_sel),
		.value_o(int2_raw)
	);

	rps_in_mux #(.NUM_PINS(NUM_PINS)) u_sck (
		.pins_i(remappable_pin_i),
		.sel_i(spi1_clock_pin_sel),
		.value_o(sck_raw)
	);

	rps_in_mux #(.NUM_PINS(NUM_PINS)) u_sdi (
		.pins_i(remappable_pin_i),
		.sel_i(spi1_data_in_pin_sel),
		.value_o(sdi_raw)
	);

	rps_out_mux #(.NUM_FUNCS(NUM_FUNCS)) u_p20 (
		.funcs_i(periph_func_i),
		.sel_i(pin20_function_sel),
		.value_o(p20_raw)
	);

	rps_out_mux #(.NUM_FUNCS(NUM_FUNCS)) u_p21 (
		.funcs_i(periph_func_i),
		.sel_i(pin21_function_sel),
		.value_o(p21_raw)
	);

	// Registered routed peripheral inputs
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			external_interrupt_two_o <= 1'b0;
			spi1_clock_in_o <= 1'b0;
			spi1_data_in_o <= 1'b0;
		end else begin
			external_interrupt_two_o <= int2_raw;
			spi1_clock_in_o <= sck_raw;
			spi1_data_in_o <= sdi_raw;
		end
	end

	// small build holds pins 20 and 21 low
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			pin20_out_o <= 1'b0;
			pin21_out_o <= 1'b0;
		end else begin
			pin20_out_o <= HAS_44_PIN ? p20_raw : 1'b0;
			pin21_out_o <= HAS_44_PIN ? p21_raw : 1'b0;
		end
	end
endmodule

// ==== verif/rps_top_props.sv ====
`timescale 1ns/10ps
module rps_top_props #(
	parameter int NUM_PINS = 26,
	parameter int NUM_FUNCS = 32,
	parameter bit HAS_44_PIN = 1'b1
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [1:0] avs_response_o,
	input wire logic [NUM_PINS-1:0] remappable_pin_i,
	input wire logic [NUM_FUNCS-1:0] periph_func_i,
	input wire logic external_interrupt_two_o,
	input wire logic spi1_clock_in_o,
	input wire logic spi1_data_in_o,
	input wire logic pin20_out_o,
	input wire logic pin21_out_o
);
	logic [4:0] s_int;
	logic lk;
	logic fresh;
	wire ans = avs_read_i && !avs_waitrequest_o;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Shadow of the interrupt selector and lock
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			s_int <= 5'h1F;
			lk <= 1'b0;
			fresh <= 1'b1;
		end else if (avs_write_i && avs_waitrequest_o) begin
			fresh <= 1'b0;
			if (avs_address_i == 4'h3 && avs_byteenable_i[0])
				lk <= avs_writedata_i[6];
			if (avs_address_i == 4'h0 && avs_byteenable_i[0] && !lk)
				s_int <= avs_writedata_i[4:0];
		end
	end
	AST_INT2_ROUTE: assert property ($past(reset_n_i) |->
		external_interrupt_two_o ==
		$past(s_int < 26 ? remappable_pin_i[s_int] : 1'b0))
		else $error("interrupt two routing wrong");
	AST_READBACK: assert property (ans && avs_address_i == 4'h0 |->
		avs_readdata_o[4:0] == s_int) else $error("selector readback wrong");
	AST_INT2_RSV: assert property (ans && avs_address_i == 4'h0 |->
		avs_readdata_o[15:5] == 11'h0) else $error("upper bits not zero");
	AST_RSV_BITS: assert property (ans && avs_address_i inside {1, 2} |->
		avs_readdata_o[15:13] == 3'h0 && avs_readdata_o[7:5] == 3'h0)
		else $error("unused bits not zero");
	AST_MAP_OK: assert property (ans && (avs_address_i <= 4'h1 ||
		avs_address_i == 4'h3 || (HAS_44_PIN && avs_address_i == 4'h2)) |->
		avs_response_o == 2'h0 && avs_readdata_o[31:16] == 16'h0)
		else $error("mapped read wrong");
	AST_SMALL_GONE: assert property (ans && !HAS_44_PIN &&
		avs_address_i == 4'h2 |->
		avs_response_o == 2'h3 && avs_readdata_o == 32'h0)
		else $error("pin register present in small build");
	AST_IN_RESET: assert property (fresh |->
		!external_interrupt_two_o && !spi1_clock_in_o && !spi1_data_in_o)
		else $error("input not low");
	AST_OUT_RESET: assert property (fresh && $past(reset_n_i) |->
		pin20_out_o == (HAS_44_PIN && $past(periph_func_i[0])) &&
		pin21_out_o == (HAS_44_PIN && $past(periph_func_i[0])))
		else $error("pin reset");
	AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("wait low too long");
	cover property (ans && avs_address_i == 4'h1);
	cover property (!fresh && external_interrupt_two_o);
	cover property (ans && avs_response_o == 2'h3);
endmodule

// ==== verif/rps_top_tb.sv ====
`timescale 1ns/10ps
module rps_top_tb;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [1:0] avs_response_o;
	// Pins and function zero high so tie-low and reset values show
	logic [25:0] remappable_pin_i = 26'h3FF_FFFF;
	logic [31:0] periph_func_i = 32'h0000_0001;
	logic external_interrupt_two_o, spi1_clock_in_o, spi1_data_in_o;
	logic pin20_out_o, pin21_out_o;
	// Outputs of the build without the pin 20/21 register
	logic [31:0] sm_readdata;
	logic sm_waitrequest;
	logic [1:0] sm_response;
	logic sm_int2, sm_sck, sm_sdi, sm_p20, sm_p21;
	int n_errors = 0;
	int n_compared = 0;
	int codes[5] = '{0, 13, 25, 26, 31};
	logic [15:0] rdat;
	logic [1:0] rsp;
	logic [15:0] srdat;
	logic [1:0] srsp;
	rps_top dut (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o),
		.avs_response_o(avs_response_o),
		.remappable_pin_i(remappable_pin_i),
		.periph_func_i(periph_func_i),
		.external_interrupt_two_o(external_interrupt_two_o),
		.spi1_clock_in_o(spi1_clock_in_o),
		.spi1_data_in_o(spi1_data_in_o),
		.pin20_out_o(pin20_out_o),
		.pin21_out_o(pin21_out_o)
	);
	// Same bus and pins, build without the pin 20/21 register
	rps_top #(.HAS_44_PIN(1'b0)) dut_small (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(sm_readdata),
		.avs_waitrequest_o(sm_waitrequest),
		.avs_response_o(sm_response),
		.remappable_pin_i(remappable_pin_i),
		.periph_func_i(periph_func_i),
		.external_interrupt_two_o(sm_int2),
		.spi1_clock_in_o(sm_sck),
		.spi1_data_in_o(sm_sdi),
		.pin20_out_o(sm_p20),
		.pin21_out_o(sm_p21)
	);
	// Clock
	always #2 core_clk_i = ~core_clk_i;
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One bus cycle, held until waitrequest low
	task automatic bus(input logic [3:0] a, input logic w, input logic [15:0] d);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= {16'h0, d};
		@(posedge core_clk_i);
		while ((avs_waitrequest_o !== 1'b0 || sm_waitrequest !== 1'b0) &&
			n < 20) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n == 20) begin
			n_errors++;
			$display("mismatch waitrequest expected 0 seen 1");
		end
		rdat = avs_readdata_o[15:0];
		rsp = avs_response_o;
		srdat = sm_readdata[15:0];
		srsp = sm_response;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [15:0] e, input logic [1:0] r);
		bus(a, 1'b0, 16'h0);
		chk("readdata", e, rdat);
		chk("response", {14'h0, r}, {14'h0, rsp});
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk_i);
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial begin
		#20000;
		n_errors++;
		test_done();
	end
	initial begin
		tick(12);
		reset_n_i <= 1'b1;
		tick(1);
		rdc(4'h0, 16'h001F, 2'h0);
		rdc(4'h1, 16'h1F1F, 2'h0);
		rdc(4'h2, 16'h0000, 2'h0);
		chk("small readdata", 16'h0000, srdat);
		chk("small response", 16'h0003, {14'h0, srsp});
		chk("tied inputs", 16'h0000, {13'h0, external_interrupt_two_o,
			spi1_clock_in_o, spi1_data_in_o});
		chk("pin reset", 16'h0003, {14'h0, pin21_out_o, pin20_out_o});
		chk("small pins", 16'h0000, {14'h0, sm_p21, sm_p20});
		$display("test reset done");
		foreach (codes[i]) begin
			bus(4'h0, 1'b1, {11'h7FF, codes[i][4:0]});
			rdc(4'h0, {11'h0, codes[i][4:0]}, 2'h0);
			remappable_pin_i <= 26'h1 << codes[i];
			tick(2);
			chk("int2", {15'h0, codes[i] < 26}, {15'h0, external_interrupt_two_o});
			remappable_pin_i <= ~(26'h1 << codes[i]);
			tick(2);
			chk("int2", 16'h0, {15'h0, external_interrupt_two_o});
		end
		$display("test input routing done");
		bus(4'h1, 1'b1, 16'hEAE5);
		rdc(4'h1, 16'h0A05, 2'h0);
		remappable_pin_i <= 26'h1 << 10;
		tick(2);
		chk("spi1", 16'h2, {14'h0, spi1_clock_in_o, spi1_data_in_o});
		remappable_pin_i <= 26'h1 << 5;
		tick(2);
		chk("spi1", 16'h1, {14'h0, spi1_clock_in_o, spi1_data_in_o});
		bus(4'h2, 1'b1, 16'hF3E7);
		rdc(4'h2, 16'h1307, 2'h0);
		chk("small readdata", 16'h0000, srdat);
		chk("small response", 16'h0003, {14'h0, srsp});
		periph_func_i <= 32'h1 << 19;
		tick(2);
		chk("pins", 16'h2, {14'h0, pin21_out_o, pin20_out_o});
		chk("small pins", 16'h0000, {14'h0, sm_p21, sm_p20});
		periph_func_i <= 32'h1 << 7;
		tick(2);
		chk("pins", 16'h1, {14'h0, pin21_out_o, pin20_out_o});
		$display("test spi and pins done");
		bus(4'h3, 1'b1, 16'h0040);
		rdc(4'h3, 16'h0040, 2'h0);
		bus(4'h0, 1'b1, 16'h0003);
		bus(4'h2, 1'b1, 16'h0000);
		rdc(4'h0, 16'h001F, 2'h0);
		rdc(4'h2, 16'h1307, 2'h0);
		bus(4'h3, 1'b1, 16'h0000);
		bus(4'h0, 1'b1, 16'h0003);
		rdc(4'h0, 16'h0003, 2'h0);
		rdc(4'h5, 16'h0000, 2'h3);
		$display("test lock and unmapped done");
		test_done();
	end
endmodule
bind rps_top rps_top_props #(
	.NUM_PINS(NUM_PINS),
	.NUM_FUNCS(NUM_FUNCS),
	.HAS_44_PIN(HAS_44_PIN)
) u_props (
	.core_clk_i(core_clk_i),
	.reset_n_i(reset_n_i),
	.avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i),
	.avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o),
	.avs_response_o(avs_response_o),
	.remappable_pin_i(remappable_pin_i),
	.periph_func_i(periph_func_i),
	.external_interrupt_two_o(external_interrupt_two_o),
	.spi1_clock_in_o(spi1_clock_in_o),
	.spi1_data_in_o(spi1_data_in_o),
	.pin20_out_o(pin20_out_o),
	.pin21_out_o(pin21_out_o)
);
